// ===== src/local_config_params.svh
// offsets, field positions, reset values, bus commands and window sizes of the local configuration bank
`ifndef LOCAL_CONFIG_PARAMS_SVH
`define LOCAL_CONFIG_PARAMS_SVH

// ************ register offsets ************
`define OFS_MODE_ARBITRATION 8'h08
`define OFS_BYTE_ORDER 8'h0C
`define OFS_INT_CTRL_STATUS 8'h68
`define OFS_CORE_FEATURE_REV 8'h74
`define OFS_DMA0_MODE 8'h80
`define OFS_DMA0_HOST_ADDR 8'h84
`define OFS_DMA0_LOCAL_ADDR 8'h88
`define OFS_DMA0_BYTE_COUNT 8'h8C
`define OFS_DMA0_DESC_PTR 8'h90
`define OFS_DMA0_CTRL_STATUS 8'hA8
`define OFS_MODE_ARB_ALIAS 8'hAC
`define OFS_DMA0_UPPER_ADDR 8'hB4
`define OFS_PIO_ADDR_RANGE 8'hF0
`define OFS_PIO_BASE_REMAP 8'hF4

// ************ field positions ************
`define BIT_DELAYED_READ 24
`define BIT_PIO_BIG_ENDIAN 5
`define BIT_DMA0_BIG_ENDIAN 7
`define BIT_GLOBAL_INT_EN 8
`define BIT_LOCAL_INT_EN 11
`define BIT_LOCAL_INT_ACTIVE 15
`define BIT_DMA0_INT_EN 18
`define BIT_DMA0_INT_ACTIVE 21
`define BIT_DMA0_SG_MODE 9
`define BIT_DMA0_DONE 4
`define DMA0_CSR_CTRL_MASK 32'h0000000F
`define DMA0_COUNT_MASK 32'h007FFFFF

// ************ reset and fixed values ************
`define MODE_ARB_FIXED 32'h02040000
`define INT_CSR_FIXED 32'h0F010000
`define DMA0_MODE_FIXED 32'h00020583
`define INT_PIN_CODE 8'h01

// ************ bus commands and window sizes ************
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define MEM_WINDOW_BITS 9
`define IO_WINDOW_BITS 8

`endif

// ===== src/local_config_pkg.sv
// types of the local configuration bank
`default_nettype none
package local_config_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CLAIM = 3'b001,
    S_XFER = 3'b010,
    S_RETRY = 3'b011,
    S_TURN = 3'b100
  } target_state_t;
  typedef logic [31:0] word_t;
endpackage : local_config_pkg
`default_nettype wire

// ===== src/local_config_interrupt_regs.sv
// local configuration and interrupt register bank, host bus target side
`include "local_config_params.svh"
`default_nettype none
module local_config_interrupt_regs #(
  parameter logic [7:0] CORE_REVISION = 8'h01,
  parameter logic [31:0] PIO_RANGE_VALUE = 32'hFF000000
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [31:0] bar0_base,
  input wire logic [31:0] bar1_base,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [3:0] cbe_n,
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe,
  output logic trdy_n_o,
  output logic trdy_oe,
  output logic devsel_n_o,
  output logic devsel_oe,
  output logic stop_n_o,
  output logic stop_oe,
  output logic inta_n_o,
  output logic inta_oe,
  output logic [7:0] interrupt_pin_code,
  input wire logic local_interrupt_input_n,
  input wire logic dma0_done,
  output logic pio_big_endian,
  output logic dma0_big_endian,
  output logic [31:0] pio_base_remap
);
  import local_config_pkg::*;

  // ************ helpers ************
  function automatic word_t merge_bytes(input word_t old_w, input word_t new_w, input logic [3:0] be_n);
    word_t r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (!be_n[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // ************ state ************
  target_state_t state_r;
  logic is_write_r;
  logic [7:0] ofs_r;
  logic delayed_read_r;
  logic global_en_r;
  logic local_en_r;
  logic dma0_en_r;
  logic dma0_done_r;
  logic [3:0] dma0_ctrl_r;
  logic dma0_sg_r;
  word_t dma0_host_addr_r;
  word_t dma0_local_addr_r;
  word_t dma0_count_r;
  word_t dma0_desc_r;
  word_t dma0_upper_r;
  logic lint_meta_r;
  logic lint_sync_r;
  logic pend_valid_r;
  logic pend_ready_r;
  logic [7:0] pend_ofs_r;
  word_t pend_data_r;
  logic [3:0] cmd;
  logic mem_hit;
  logic io_hit;
  logic wr_now;
  logic dma0_clear;
  word_t rd_word;

  // ************ decode ************
  assign cmd = cbe_n;
  assign mem_hit = ((cmd == `CMD_MEM_READ) || (cmd == `CMD_MEM_WRITE)) &&
                   (ad_i[31:`MEM_WINDOW_BITS] == bar0_base[31:`MEM_WINDOW_BITS]);
  assign io_hit = ((cmd == `CMD_IO_READ) || (cmd == `CMD_IO_WRITE)) &&
                  (ad_i[31:`IO_WINDOW_BITS] == bar1_base[31:`IO_WINDOW_BITS]);
  assign wr_now = (state_r == S_XFER) && is_write_r && !irdy_n;

  // read mux; upper half of the memory window reads zero
  always_comb begin
    rd_word = 32'h00000000;
    case (ofs_r)
      `OFS_MODE_ARBITRATION, `OFS_MODE_ARB_ALIAS: begin
        rd_word = `MODE_ARB_FIXED;
        rd_word[`BIT_DELAYED_READ] = delayed_read_r;
      end
      `OFS_BYTE_ORDER: begin
        rd_word[`BIT_PIO_BIG_ENDIAN] = pio_big_endian;
        rd_word[`BIT_DMA0_BIG_ENDIAN] = dma0_big_endian;
      end
      `OFS_INT_CTRL_STATUS: begin
        rd_word = `INT_CSR_FIXED;
        rd_word[`BIT_GLOBAL_INT_EN] = global_en_r;
        rd_word[`BIT_LOCAL_INT_EN] = local_en_r;
        rd_word[`BIT_LOCAL_INT_ACTIVE] = lint_sync_r;
        rd_word[`BIT_DMA0_INT_EN] = dma0_en_r;
        rd_word[`BIT_DMA0_INT_ACTIVE] = dma0_done_r;
      end
      `OFS_CORE_FEATURE_REV: begin
        rd_word[7:0] = CORE_REVISION;
      end
      `OFS_DMA0_MODE: begin
        rd_word = `DMA0_MODE_FIXED;
        rd_word[`BIT_DMA0_SG_MODE] = dma0_sg_r;
      end
      `OFS_DMA0_HOST_ADDR: begin
        rd_word = dma0_host_addr_r;
      end
      `OFS_DMA0_LOCAL_ADDR: begin
        rd_word = dma0_local_addr_r;
      end
      `OFS_DMA0_BYTE_COUNT: begin
        rd_word = dma0_count_r;
      end
      `OFS_DMA0_DESC_PTR: begin
        rd_word = dma0_desc_r;
      end
      `OFS_DMA0_CTRL_STATUS: begin
        rd_word[3:0] = dma0_ctrl_r;
        rd_word[`BIT_DMA0_DONE] = dma0_done_r;
      end
      `OFS_DMA0_UPPER_ADDR: begin
        rd_word = dma0_upper_r;
      end
      `OFS_PIO_ADDR_RANGE: begin
        rd_word = PIO_RANGE_VALUE;
      end
      `OFS_PIO_BASE_REMAP: begin
        rd_word = pio_base_remap;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // ************ target sequencer ************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      is_write_r <= 1'b0;
      ofs_r <= 8'h00;
      ad_o <= 32'h00000000;
      ad_oe <= 1'b0;
      trdy_n_o <= 1'b1;
      trdy_oe <= 1'b0;
      devsel_n_o <= 1'b1;
      devsel_oe <= 1'b0;
      stop_n_o <= 1'b1;
      stop_oe <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (!frame_n && (mem_hit || io_hit)) begin
            is_write_r <= cmd[0];
            ofs_r <= (ad_i[8] && mem_hit) ? 8'hFF : {ad_i[7:2], 2'b00};
            devsel_n_o <= 1'b0;
            devsel_oe <= 1'b1;
            trdy_oe <= 1'b1;
            stop_oe <= 1'b1;
            state_r <= S_CLAIM;
          end
        end
        S_CLAIM: begin
          if (!is_write_r && delayed_read_r && !(pend_ready_r && pend_ofs_r == ofs_r)) begin
            stop_n_o <= 1'b0;
            state_r <= S_RETRY;
          end else begin
            ad_o <= (!is_write_r && delayed_read_r) ? pend_data_r : rd_word;
            ad_oe <= !is_write_r;
            trdy_n_o <= 1'b0;
            stop_n_o <= 1'b0;
            state_r <= S_XFER;
          end
        end
        S_XFER: begin
          if (!irdy_n) begin
            trdy_n_o <= 1'b1;
            devsel_n_o <= 1'b1;
            stop_n_o <= 1'b1;
            ad_oe <= 1'b0;
            state_r <= S_TURN;
          end
        end
        S_RETRY: begin
          if (frame_n) begin
            devsel_n_o <= 1'b1;
            stop_n_o <= 1'b1;
            state_r <= S_TURN;
          end
        end
        S_TURN: begin
          trdy_oe <= 1'b0;
          devsel_oe <= 1'b0;
          stop_oe <= 1'b0;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ************ delayed read fetch ************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_valid_r <= 1'b0;
      pend_ready_r <= 1'b0;
      pend_ofs_r <= 8'h00;
      pend_data_r <= 32'h00000000;
    end else if (state_r == S_CLAIM && !is_write_r && delayed_read_r) begin
      if (pend_ready_r && pend_ofs_r == ofs_r) begin
        pend_valid_r <= 1'b0;
        pend_ready_r <= 1'b0;
      end else if (!pend_valid_r) begin
        pend_valid_r <= 1'b1;
        pend_ofs_r <= ofs_r;
      end
    end else if (pend_valid_r && !pend_ready_r) begin
      pend_data_r <= rd_word;
      pend_ready_r <= 1'b1;
    end else if (!delayed_read_r) begin
      pend_valid_r <= 1'b0;
      pend_ready_r <= 1'b0;
    end
  end

  // ************ mode and byte order ************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      delayed_read_r <= 1'b0;
      pio_big_endian <= 1'b0;
      dma0_big_endian <= 1'b0;
    end else if (wr_now) begin
      if ((ofs_r == `OFS_MODE_ARBITRATION || ofs_r == `OFS_MODE_ARB_ALIAS) && !cbe_n[3]) begin
        delayed_read_r <= ad_i[`BIT_DELAYED_READ];
      end
      if (ofs_r == `OFS_BYTE_ORDER && !cbe_n[0]) begin
        pio_big_endian <= ad_i[`BIT_PIO_BIG_ENDIAN];
        dma0_big_endian <= ad_i[`BIT_DMA0_BIG_ENDIAN];
      end
    end
  end

  // ************ interrupt control ************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      global_en_r <= 1'b1;
      local_en_r <= 1'b0;
      dma0_en_r <= 1'b0;
    end else if (wr_now && ofs_r == `OFS_INT_CTRL_STATUS) begin
      if (!cbe_n[1]) begin
        global_en_r <= ad_i[`BIT_GLOBAL_INT_EN];
        local_en_r <= ad_i[`BIT_LOCAL_INT_EN];
      end
      if (!cbe_n[2]) begin
        dma0_en_r <= ad_i[`BIT_DMA0_INT_EN];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lint_meta_r <= 1'b0;
      lint_sync_r <= 1'b0;
    end else begin
      lint_meta_r <= !local_interrupt_input_n;
      lint_sync_r <= lint_meta_r;
    end
  end

  // dma done flag: set wins over the write-one clear
  assign dma0_clear = wr_now && ofs_r == `OFS_DMA0_CTRL_STATUS && !cbe_n[0] && ad_i[`BIT_DMA0_DONE];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dma0_done_r <= 1'b0;
    end else if (dma0_done) begin
      dma0_done_r <= 1'b1;
    end else if (dma0_clear) begin
      dma0_done_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      inta_n_o <= 1'b0;
      inta_oe <= 1'b0;
      interrupt_pin_code <= 8'h00;
    end else begin
      inta_n_o <= 1'b0;
      inta_oe <= global_en_r && ((local_en_r && lint_sync_r) || (dma0_en_r && dma0_done_r));
      interrupt_pin_code <= `INT_PIN_CODE;
    end
  end

  // ************ dma channel 0 and remap storage ************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dma0_sg_r <= 1'b0;
      dma0_ctrl_r <= 4'h0;
      dma0_host_addr_r <= 32'h00000000;
      dma0_local_addr_r <= 32'h00000000;
      dma0_count_r <= 32'h00000000;
      dma0_desc_r <= 32'h00000000;
      dma0_upper_r <= 32'h00000000;
      pio_base_remap <= 32'h00000000;
    end else if (wr_now) begin
      case (ofs_r)
        `OFS_DMA0_MODE: begin
          if (!cbe_n[1]) begin
            dma0_sg_r <= ad_i[`BIT_DMA0_SG_MODE];
          end
        end
        `OFS_DMA0_CTRL_STATUS: begin
          if (!cbe_n[0]) begin
            dma0_ctrl_r <= ad_i[3:0];
          end
        end
        `OFS_DMA0_HOST_ADDR: begin
          dma0_host_addr_r <= merge_bytes(dma0_host_addr_r, ad_i, cbe_n);
        end
        `OFS_DMA0_LOCAL_ADDR: begin
          dma0_local_addr_r <= merge_bytes(dma0_local_addr_r, ad_i, cbe_n);
        end
        `OFS_DMA0_BYTE_COUNT: begin
          dma0_count_r <= merge_bytes(dma0_count_r, ad_i, cbe_n) & `DMA0_COUNT_MASK;
        end
        `OFS_DMA0_DESC_PTR: begin
          dma0_desc_r <= merge_bytes(dma0_desc_r, ad_i, cbe_n);
        end
        `OFS_DMA0_UPPER_ADDR: begin
          dma0_upper_r <= merge_bytes(dma0_upper_r, ad_i, cbe_n);
        end
        `OFS_PIO_BASE_REMAP: begin
          pio_base_remap <= merge_bytes(pio_base_remap, ad_i, cbe_n);
        end
        default: begin
        end
      endcase
    end
  end

endmodule : local_config_interrupt_regs
`default_nettype wire

// ===== test/local_config_interrupt_regs_monitor.sv
// checker of target handshake and interrupt pin
`default_nettype none
module local_config_interrupt_regs_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [31:0] bar0_base,
  input wire logic [31:0] bar1_base,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [3:0] cbe_n,
  input wire logic [31:0] ad_i,
  input wire logic trdy_n_o,
  input wire logic trdy_oe,
  input wire logic devsel_n_o,
  input wire logic devsel_oe,
  input wire logic stop_n_o,
  input wire logic inta_n_o,
  input wire logic inta_oe,
  input wire logic [7:0] interrupt_pin_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_mem_claim;
    !frame_n && $past(frame_n) && cbe_n[3:1] == 3'b011 && ad_i[31:9] == bar0_base[31:9];
  endsequence
  sequence s_io_claim;
    !frame_n && $past(frame_n) && cbe_n[3:1] == 3'b001 && ad_i[31:8] == bar1_base[31:8];
  endsequence
  sequence s_data_done;
    trdy_oe && !trdy_n_o && !irdy_n;
  endsequence
  chk_mem_claim: assert property (s_mem_claim |-> ##[1:2] (devsel_oe && !devsel_n_o))
    else $error("memory cycle not claimed");
  chk_io_claim: assert property (s_io_claim |-> ##[1:2] (devsel_oe && !devsel_n_o))
    else $error("io cycle not claimed");
  chk_stop_follows: assert property (s_mem_claim |-> ##[2:3] !stop_n_o)
    else $error("no disconnect or retry");
  chk_trdy_holds: assert property (trdy_oe && !trdy_n_o && irdy_n |=> !trdy_n_o)
    else $error("ready dropped early");
  chk_phase_ends: assert property (s_data_done |=> ##[0:1] (trdy_n_o && devsel_n_o) ##[1:2] !devsel_oe)
    else $error("data phase not ended");
  chk_devsel_with: assert property (trdy_oe && !trdy_n_o |-> devsel_oe && !devsel_n_o)
    else $error("ready without select");
  chk_inta_low: assert property (inta_oe |-> !inta_n_o)
    else $error("interrupt line driven high");
  chk_pin_code: assert property ($past(rstn) |-> interrupt_pin_code == 8'h01)
    else $error("wrong interrupt pin code");
endmodule : local_config_interrupt_regs_monitor
bind local_config_interrupt_regs local_config_interrupt_regs_monitor i_local_config_interrupt_regs_monitor (
  .clock(clock), .rstn(rstn), .bar0_base(bar0_base), .bar1_base(bar1_base), .frame_n(frame_n),
  .irdy_n(irdy_n), .cbe_n(cbe_n), .ad_i(ad_i), .trdy_n_o(trdy_n_o), .trdy_oe(trdy_oe),
  .devsel_n_o(devsel_n_o), .devsel_oe(devsel_oe), .stop_n_o(stop_n_o), .inta_n_o(inta_n_o),
  .inta_oe(inta_oe), .interrupt_pin_code(interrupt_pin_code));
`default_nettype wire

// ===== test/host_bus_model.sv
// host bus master model issuing single-word cycles
`default_nettype none
module host_bus_model (
  input wire logic clock,
  output logic frame_n,
  output logic irdy_n,
  output logic [3:0] cbe_n,
  output logic [31:0] ad_i,
  input wire logic [31:0] ad_o,
  input wire logic trdy_n_o,
  input wire logic trdy_oe,
  input wire logic stop_n_o,
  input wire logic stop_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_n = 1'b1;
    irdy_n = 1'b1;
    cbe_n = 4'hF;
    ad_i = 32'h00000000;
  end
  task automatic access(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic retried);
    rd = 32'hXXXXXXXX;
    retried = 1'b0;
    @(posedge clock);
    frame_n <= 1'b0;
    cbe_n <= cmd;
    ad_i <= addr;
    @(posedge clock);
    frame_n <= 1'b1;
    irdy_n <= 1'b0;
    cbe_n <= 4'h0;
    ad_i <= cmd[0] ? wd : ~addr;
    for (int n = 0; n < 16; n++) begin
      @(posedge clock);
      if (trdy_oe && !trdy_n_o) begin
        rd = ad_o;
        break;
      end
      if (stop_oe && !stop_n_o) begin
        retried = 1'b1;
        break;
      end
    end
    irdy_n <= 1'b1;
    cbe_n <= 4'hF;
    ad_i <= ~ad_i;
    repeat (2) @(posedge clock);
  endtask : access
endmodule : host_bus_model
`default_nettype wire

// ===== test/local_config_interrupt_regs_tb.sv
// self-checking bench of the local configuration register bank
`default_nettype none
module local_config_interrupt_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BAR0 = 32'h40000000;
  localparam logic [31:0] BAR1 = 32'h00001000;
  logic clock, rstn, lint_n, dma0_done, ad_oe, trdy_n_o, trdy_oe, devsel_n_o, devsel_oe;
  logic stop_n_o, stop_oe, inta_n_o, inta_oe, pio_be, dma_be, rt;
  logic [7:0] pin_code;
  logic [31:0] ad_o, remap, rdv;
  wire logic frame_n, irdy_n;
  wire logic [3:0] cbe_n;
  wire logic [31:0] ad_i;
  int failures = 0;
  int samples_checked = 0;
  local_config_interrupt_regs i_local_config_interrupt_regs (.clock(clock), .rstn(rstn),
    .bar0_base(BAR0), .bar1_base(BAR1), .frame_n(frame_n), .irdy_n(irdy_n), .cbe_n(cbe_n),
    .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe), .trdy_n_o(trdy_n_o), .trdy_oe(trdy_oe),
    .devsel_n_o(devsel_n_o), .devsel_oe(devsel_oe), .stop_n_o(stop_n_o), .stop_oe(stop_oe),
    .inta_n_o(inta_n_o), .inta_oe(inta_oe), .interrupt_pin_code(pin_code),
    .local_interrupt_input_n(lint_n), .dma0_done(dma0_done), .pio_big_endian(pio_be),
    .dma0_big_endian(dma_be), .pio_base_remap(remap));
  host_bus_model i_host_bus_model (.clock(clock), .frame_n(frame_n), .irdy_n(irdy_n), .cbe_n(cbe_n),
    .ad_i(ad_i), .ad_o(ad_o), .trdy_n_o(trdy_n_o), .trdy_oe(trdy_oe), .stop_n_o(stop_n_o),
    .stop_oe(stop_oe));
  // ************
  // helpers
  // ************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] base, input logic [7:0] ofs,
                      input logic [31:0] wd);
    for (int k = 0; k < 4; k++) begin
      i_host_bus_model.access(cmd, base | {24'h000000, ofs}, wd, rdv, rt);
      if (!rt) break;
    end
  endtask : xfer
  task automatic wrap_up();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // ************
  // scenarios
  // ************
  task automatic t_reset_values();
    xfer(4'h6, BAR0, 8'h68, 32'h0);
    chk("int_csr", 32'h0F010100, rdv);
    xfer(4'h6, BAR0, 8'h08, 32'h0);
    chk("mode", 32'h02040000, rdv);
    xfer(4'h2, BAR1, 8'h0C, 32'h0);
    chk("byte_order", 32'h00000000, rdv);
    chk("pin_code", 32'h00000001, {24'h0, pin_code});
  endtask : t_reset_values
  task automatic t_alias_delayed();
    xfer(4'h7, BAR0, 8'hAC, 32'h01000000);
    i_host_bus_model.access(4'h6, BAR0 | 32'h08, 32'h0, rdv, rt);
    chk("retry", 32'h1, {31'h0, rt});
    xfer(4'h6, BAR0, 8'h08, 32'h0);
    chk("mode", 32'h03040000, rdv);
    xfer(4'h7, BAR0, 8'h08, 32'h0);
    xfer(4'h6, BAR0, 8'hAC, 32'h0);
    chk("mode_alias", 32'h02040000, rdv);
  endtask : t_alias_delayed
  task automatic t_byte_order();
    xfer(4'h3, BAR1, 8'h0C, 32'hA0);
    chk("pio_be", 32'h1, {31'h0, pio_be});
    chk("dma_be", 32'h1, {31'h0, dma_be});
    xfer(4'h7, BAR0, 8'h0C, 32'h80);
    chk("pio_be", 32'h0, {31'h0, pio_be});
    xfer(4'h2, BAR1, 8'h0C, 32'h0);
    chk("byte_order", 32'h80, rdv);
  endtask : t_byte_order
  task automatic t_pio_regs();
    xfer(4'h7, BAR0, 8'hF4, 32'h12345678);
    chk("remap", 32'h12345678, remap);
    xfer(4'h7, BAR0, 8'hF0, 32'h0);
    xfer(4'h6, BAR0, 8'hF0, 32'h0);
    chk("pio_range", 32'hFF000000, rdv);
  endtask : t_pio_regs
  task automatic t_interrupts();
    lint_n <= 1'b0;
    repeat (4) @(posedge clock);
    chk("inta", 32'h0, {31'h0, inta_oe});
    xfer(4'h6, BAR0, 8'h68, 32'h0);
    chk("int_csr", 32'h0F018100, rdv);
    xfer(4'h7, BAR0, 8'h68, 32'h00000900);
    repeat (2) @(posedge clock);
    chk("inta", 32'h1, {31'h0, inta_oe});
    xfer(4'h7, BAR0, 8'h68, 32'h00000800);
    repeat (2) @(posedge clock);
    chk("inta", 32'h0, {31'h0, inta_oe});
    lint_n <= 1'b1;
    xfer(4'h7, BAR0, 8'h68, 32'h00040100);
    dma0_done <= 1'b1;
    @(posedge clock);
    dma0_done <= 1'b0;
    repeat (2) @(posedge clock);
    chk("inta", 32'h1, {31'h0, inta_oe});
    xfer(4'h6, BAR0, 8'h68, 32'h0);
    chk("int_csr", 32'h0F250100, rdv);
    xfer(4'h7, BAR0, 8'hA8, 32'h10);
    repeat (2) @(posedge clock);
    chk("inta", 32'h0, {31'h0, inta_oe});
    xfer(4'h6, BAR0, 8'h68, 32'h0);
    chk("int_csr", 32'h0F050100, rdv);
  endtask : t_interrupts
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    rstn = 1'b0;
    lint_n = 1'b1;
    dma0_done = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    t_reset_values();
    t_alias_delayed();
    t_byte_order();
    t_pio_regs();
    t_interrupts();
    wrap_up();
  end
  initial begin
    #(40 * 20000);
    failures++;
    wrap_up();
  end
endmodule : local_config_interrupt_regs_tb
`default_nettype wire
